// ===== rtl/ds3pc_pkg.sv
// Constants for the port control register bank
`default_nettype none
package ds3pc_pkg;
    // Register offsets
    localparam logic [7:0]  ADDR_CTRL1    = 8'h40;
    localparam logic [7:0]  ADDR_CTRL2    = 8'h42;
    localparam logic [7:0]  ADDR_CTRL3    = 8'h44;
    localparam logic [7:0]  ADDR_CTRL4    = 8'h46;
    localparam logic [7:0]  ADDR_INV1     = 8'h4A;
    localparam logic [7:0]  ADDR_INV2     = 8'h4C;
    localparam logic [7:0]  ADDR_ISR      = 8'h50;
    localparam logic [7:0]  ADDR_STAT     = 8'h52;
    localparam logic [7:0]  ADDR_STATL    = 8'h54;
    localparam logic [7:0]  ADDR_STATIE   = 8'h56;
    // Writable bit masks
    localparam logic [15:0] MASK_CTRL1    = 16'h7EDF;
    localparam logic [15:0] MASK_CTRL2    = 16'hF738;
    localparam logic [15:0] MASK_CTRL3    = 16'h36FF;
    localparam logic [15:0] MASK_CTRL4    = 16'h07FF;
    localparam logic [15:0] MASK_INV      = 16'hFFFF;
    localparam logic [15:0] MASK_STAT     = 16'h000F;
    // Reset values
    localparam logic [15:0] RST_CTRL1     = 16'h0006;
    localparam logic [15:0] RST_ZERO      = 16'h0000;
    // Control 1 fields
    localparam int          PAS_MSB       = 14;
    localparam int          PAS_LSB       = 12;
    localparam int          LAS_MSB       = 11;
    localparam int          LAS_LSB       = 10;
    localparam int          BIT_PGEN      = 9;
    localparam int          BIT_MEI       = 7;
    localparam int          BIT_EISRC     = 6;
    localparam int          BIT_PUSRC     = 4;
    localparam int          BIT_PUPD      = 3;
    localparam int          BIT_PDN       = 2;
    localparam int          BIT_DPRST     = 1;
    localparam int          BIT_SRST      = 0;
    // Control 2 fields
    localparam int          BIT_TX_LINE_OUTPUT_ENABLE      = 15;
    localparam int          BIT_TTS       = 14;
    localparam int          BIT_PREAMP    = 13;
    localparam int          BIT_BLDOUT    = 12;
    localparam int          LIM_MSB       = 10;
    localparam int          LIM_LSB       = 8;
    localparam int          BIT_FM_E3     = 4;
    // Control 4 loopback field
    localparam int          LBS_MSB       = 10;
    localparam int          LBS_LSB       = 8;
    // Line code output values
    localparam logic [1:0]  CODE_ZS       = 2'h0;
    localparam logic [1:0]  CODE_AMI      = 2'h1;
    localparam logic [1:0]  CODE_UNI      = 2'h2;
    // Least datapath reset hold time
    localparam int          RST_HOLD_NS   = 100;
    localparam int          CLK_PERIOD_NS = 40;
    localparam int          RST_HOLD_CYC  = (RST_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage
`default_nettype wire

// ===== rtl/ds3pc_port_ctrl.sv
// Port control register bank with line, alarm and reset control
//
// Notes on behaviour
// - Payload all-ones forced per three-bit select
// - Code 110 combines conditions; 101 frame loss
// - Line alarm: auto, all-ones, AIS, or off
// - Line alarm overrides framer, even in loopback
// - Pattern generator gated by its enable bit
// - Enabled generator replaces system serial data
// - Manual inject rising edge makes one error
// - Error source: port bit or global
// - Counter update source: port bit or global
// - Update rising edge latches and clears counters
// - Done flag clears when selected update request falls
// - Power-down stops port clocks, defaults set
// - Datapath reset held, at least 100ns
// - Datapath reset bit set after any reset
// - Soft reset clears port, not itself
// - Port reset ORs soft, global, pin
// - Output enable low forces line outputs low
// - Tristate only acts while interface powered
// - Monitor pre-amp follows its bit
// - Build-out only in DS3 interface mode
// - Mode selects interface and attenuator placement
// - Zero-suppress-off bits choose B3ZS/HDB3 or AMI
//
// The implementer's own choice: the plain strobed port.
`default_nettype none
module ds3pc_port_ctrl (
    input  wire logic        REF_CLK_I,
    input  wire logic        RST_I,
    input  wire logic [7:0]  ADDR_I,
    input  wire logic [15:0] WDATA_I,
    input  wire logic        WR_I,
    input  wire logic        RD_I,
    output logic      [15:0] RDATA_O,
    input  wire logic        HW_RESET_N_I,
    input  wire logic        GLOBAL_SOFT_RESET_I,
    input  wire logic        GLOBAL_ERR_INJECT_I,
    input  wire logic        GLOBAL_PERF_UPDATE_I,
    input  wire logic        PERF_UPDATE_ACK_I,
    input  wire logic        SIGNAL_ABSENT_I,
    input  wire logic        FRAME_SYNC_LOST_I,
    input  wire logic        TX_ZERO_SUPPRESS_OFF_I,
    input  wire logic        RX_ZERO_SUPPRESS_OFF_I,
    input  wire logic        RX_PAYLOAD_I,
    output logic             RX_PAYLOAD_O,
    input  wire logic        TX_SYSTEM_SERIAL_IN_I,
    input  wire logic        TX_PATTERN_BIT_I,
    output logic             TX_PAYLOAD_O,
    input  wire logic        TX_FRAMER_POS_I,
    input  wire logic        TX_FRAMER_NEG_I,
    input  wire logic        TX_DS3_AIS_I,
    input  wire logic        TX_LINE_CLK_I,
    output logic             TX_POSITIVE_RAIL_O,
    output logic             TX_NEGATIVE_RAIL_O,
    output logic             TX_LINE_CLOCK_OUT_O,
    output logic             LINE_DRIVER_OE_O,
    output logic             LIU_ENABLE_O,
    output logic             JA_IN_TX_O,
    output logic             JA_IN_RX_O,
    output logic      [1:0]  LINE_CODE_O,
    output logic             PREAMP_EN_O,
    output logic             BUILDOUT_EN_O,
    output logic             PORT_CLK_EN_O,
    output logic             PATTERN_GEN_EN_O,
    output logic             ERR_INJECT_O,
    output logic             PERF_LATCH_O,
    output logic             DATAPATH_RESET_O,
    output logic             PORT_RESET_O
);
    // ------------------------------------------------------------
    // Reset combination
    // ------------------------------------------------------------
    logic        hw_n_meta_ff;
    logic        hw_n_sync_ff;
    logic [15:0] ctrl1_ff, ctrl2_ff, ctrl3_ff, ctrl4_ff;
    logic [15:0] inv1_ff, inv2_ff, statie_ff, statl_ff;
    logic        port_rst;
    logic        gen_rst;
    logic        wr_c1;

    // Pin reset passes two flops; stays asserted through RST_I
    always_ff @(posedge REF_CLK_I) begin
        if (RST_I) begin
            hw_n_meta_ff <= 1'b0;
            hw_n_sync_ff <= 1'b0;
        end else begin
            hw_n_meta_ff <= HW_RESET_N_I;
            hw_n_sync_ff <= hw_n_meta_ff;
        end
    end

    assign gen_rst  = RST_I | GLOBAL_SOFT_RESET_I | ~hw_n_sync_ff;
    assign port_rst = gen_rst | ctrl1_ff[ds3pc_pkg::BIT_SRST];
    assign wr_c1    = WR_I && (ADDR_I == ds3pc_pkg::ADDR_CTRL1);

    // ------------------------------------------------------------
    // Register file
    // ------------------------------------------------------------
    // Soft reset bit is cleared by the other reset sources or a Control 1 write, not by itself
    always_ff @(posedge REF_CLK_I) begin
        if (gen_rst) begin
            ctrl1_ff[ds3pc_pkg::BIT_SRST] <= 1'b0;
        end else if (wr_c1) begin
            ctrl1_ff[ds3pc_pkg::BIT_SRST] <= WDATA_I[ds3pc_pkg::BIT_SRST];
        end
        if (port_rst) begin
            ctrl1_ff[15:1] <= ds3pc_pkg::RST_CTRL1[15:1];
        end else if (wr_c1) begin
            ctrl1_ff[15:1] <= WDATA_I[15:1] & ds3pc_pkg::MASK_CTRL1[15:1];
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (port_rst) begin
            ctrl2_ff  <= ds3pc_pkg::RST_ZERO;
            ctrl3_ff  <= ds3pc_pkg::RST_ZERO;
            ctrl4_ff  <= ds3pc_pkg::RST_ZERO;
            inv1_ff   <= ds3pc_pkg::RST_ZERO;
            inv2_ff   <= ds3pc_pkg::RST_ZERO;
            statie_ff <= ds3pc_pkg::RST_ZERO;
        end else if (WR_I) begin
            unique case (ADDR_I)
                ds3pc_pkg::ADDR_CTRL2:  ctrl2_ff  <= WDATA_I & ds3pc_pkg::MASK_CTRL2;
                ds3pc_pkg::ADDR_CTRL3:  ctrl3_ff  <= WDATA_I & ds3pc_pkg::MASK_CTRL3;
                ds3pc_pkg::ADDR_CTRL4:  ctrl4_ff  <= WDATA_I & ds3pc_pkg::MASK_CTRL4;
                ds3pc_pkg::ADDR_INV1:   inv1_ff   <= WDATA_I & ds3pc_pkg::MASK_INV;
                ds3pc_pkg::ADDR_INV2:   inv2_ff   <= WDATA_I & ds3pc_pkg::MASK_INV;
                ds3pc_pkg::ADDR_STATIE: statie_ff <= WDATA_I & ds3pc_pkg::MASK_STAT;
                default: ;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    logic [2:0] pas, lim, lbs;
    logic [1:0] las;
    logic       e3_mode, line_loopback, payload_loopback, diagnostic_loopback, liu_on, unipolar;
    assign pas      = ctrl1_ff[ds3pc_pkg::PAS_MSB:ds3pc_pkg::PAS_LSB];
    assign las      = ctrl1_ff[ds3pc_pkg::LAS_MSB:ds3pc_pkg::LAS_LSB];
    assign lim      = ctrl2_ff[ds3pc_pkg::LIM_MSB:ds3pc_pkg::LIM_LSB];
    assign lbs      = ctrl4_ff[ds3pc_pkg::LBS_MSB:ds3pc_pkg::LBS_LSB];
    assign e3_mode  = ctrl2_ff[ds3pc_pkg::BIT_FM_E3];
    assign line_loopback      = (lbs == 3'h2) || (lbs == 3'h6);
    assign payload_loopback      = (lbs == 3'h3);
    assign diagnostic_loopback      = lbs[2];
    assign unipolar = lim[2];
    assign liu_on   = !unipolar && (lim != 3'h0);

    // ------------------------------------------------------------
    // Receive payload alarm
    // ------------------------------------------------------------
    logic llb_nd, los_nd, pay_alarm;
    assign llb_nd = line_loopback && !diagnostic_loopback;
    assign los_nd = SIGNAL_ABSENT_I && !diagnostic_loopback;
    always_comb begin
        unique case (pas)
            3'h0:    pay_alarm = 1'b1;
            3'h1:    pay_alarm = llb_nd;
            3'h2:    pay_alarm = payload_loopback;
            3'h3:    pay_alarm = llb_nd || payload_loopback;
            3'h4:    pay_alarm = los_nd;
            3'h5:    pay_alarm = FRAME_SYNC_LOST_I;
            3'h6:    pay_alarm = FRAME_SYNC_LOST_I || SIGNAL_ABSENT_I || llb_nd || payload_loopback;
            default: pay_alarm = 1'b0;
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (port_rst) begin
            RX_PAYLOAD_O <= 1'b1;
        end else begin
            RX_PAYLOAD_O <= pay_alarm | RX_PAYLOAD_I;
        end
    end

    // ------------------------------------------------------------
    // Transmit payload and line outputs
    // ------------------------------------------------------------
    logic line_alarm, alarm_bit, tx_line_output_enable;
    assign line_alarm = (las == 2'h1) || (las == 2'h2) || ((las == 2'h0) && diagnostic_loopback);
    assign alarm_bit  = (las == 2'h1) || e3_mode || TX_DS3_AIS_I;
    assign tx_line_output_enable       = ctrl2_ff[ds3pc_pkg::BIT_TX_LINE_OUTPUT_ENABLE];

    always_ff @(posedge REF_CLK_I) begin
        if (port_rst) begin
            TX_PAYLOAD_O <= 1'b0;
        end else if (ctrl1_ff[ds3pc_pkg::BIT_PGEN]) begin
            TX_PAYLOAD_O <= TX_PATTERN_BIT_I;
        end else begin
            TX_PAYLOAD_O <= TX_SYSTEM_SERIAL_IN_I;
        end
    end

    // Alarm wins over framer data regardless of loopback state
    always_ff @(posedge REF_CLK_I) begin
        if (port_rst || !tx_line_output_enable) begin
            TX_POSITIVE_RAIL_O  <= 1'b0;
            TX_NEGATIVE_RAIL_O  <= 1'b0;
            TX_LINE_CLOCK_OUT_O <= 1'b0;
        end else begin
            TX_LINE_CLOCK_OUT_O <= TX_LINE_CLK_I;
            if (line_alarm) begin
                TX_POSITIVE_RAIL_O <= alarm_bit;
                TX_NEGATIVE_RAIL_O <= 1'b0;
            end else begin
                TX_POSITIVE_RAIL_O <= TX_FRAMER_POS_I;
                TX_NEGATIVE_RAIL_O <= TX_FRAMER_NEG_I;
            end
        end
    end

    // ------------------------------------------------------------
    // Line interface controls
    // ------------------------------------------------------------
    logic [1:0] nxt_code;
    always_comb begin
        if (unipolar) begin
            nxt_code = ds3pc_pkg::CODE_UNI;
        end else if (TX_ZERO_SUPPRESS_OFF_I && RX_ZERO_SUPPRESS_OFF_I) begin
            nxt_code = ds3pc_pkg::CODE_AMI;
        end else begin
            nxt_code = ds3pc_pkg::CODE_ZS;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (port_rst) begin
            LINE_DRIVER_OE_O <= 1'b0;
            LIU_ENABLE_O     <= 1'b0;
            JA_IN_TX_O       <= 1'b0;
            JA_IN_RX_O       <= 1'b0;
            LINE_CODE_O      <= ds3pc_pkg::CODE_ZS;
            PREAMP_EN_O      <= 1'b0;
            BUILDOUT_EN_O    <= 1'b0;
            PORT_CLK_EN_O    <= 1'b0;
            PATTERN_GEN_EN_O <= 1'b0;
        end else begin
            LINE_DRIVER_OE_O <= liu_on && !ctrl2_ff[ds3pc_pkg::BIT_TTS];
            LIU_ENABLE_O     <= liu_on;
            JA_IN_TX_O       <= (lim == 3'h2);
            JA_IN_RX_O       <= (lim == 3'h3);
            LINE_CODE_O      <= nxt_code;
            PREAMP_EN_O      <= ctrl2_ff[ds3pc_pkg::BIT_PREAMP];
            BUILDOUT_EN_O    <= ctrl2_ff[ds3pc_pkg::BIT_BLDOUT] && liu_on && !e3_mode;
            PORT_CLK_EN_O    <= !ctrl1_ff[ds3pc_pkg::BIT_PDN];
            PATTERN_GEN_EN_O <= ctrl1_ff[ds3pc_pkg::BIT_PGEN]
                                && !ctrl1_ff[ds3pc_pkg::BIT_PDN];
        end
    end

    // ------------------------------------------------------------
    // Error injection and counter update triggers
    // ------------------------------------------------------------
    logic mei_d_ff, gei_d_ff, pu_d_ff, gpu_d_ff, done_ff;
    logic pu_src, pu_req;
    assign pu_src = ctrl1_ff[ds3pc_pkg::BIT_PUSRC];
    assign pu_req = pu_src ? GLOBAL_PERF_UPDATE_I : ctrl1_ff[ds3pc_pkg::BIT_PUPD];

    always_ff @(posedge REF_CLK_I) begin
        if (port_rst) begin
            mei_d_ff     <= 1'b0;
            gei_d_ff     <= 1'b0;
            pu_d_ff      <= 1'b0;
            gpu_d_ff     <= 1'b0;
            ERR_INJECT_O <= 1'b0;
            PERF_LATCH_O <= 1'b0;
        end else begin
            mei_d_ff <= ctrl1_ff[ds3pc_pkg::BIT_MEI];
            gei_d_ff <= GLOBAL_ERR_INJECT_I;
            pu_d_ff  <= ctrl1_ff[ds3pc_pkg::BIT_PUPD];
            gpu_d_ff <= GLOBAL_PERF_UPDATE_I;
            if (ctrl1_ff[ds3pc_pkg::BIT_EISRC]) begin
                ERR_INJECT_O <= GLOBAL_ERR_INJECT_I && !gei_d_ff;
            end else begin
                ERR_INJECT_O <= ctrl1_ff[ds3pc_pkg::BIT_MEI] && !mei_d_ff;
            end
            if (pu_src) begin
                PERF_LATCH_O <= GLOBAL_PERF_UPDATE_I && !gpu_d_ff;
            end else begin
                PERF_LATCH_O <= ctrl1_ff[ds3pc_pkg::BIT_PUPD] && !pu_d_ff;
            end
        end
    end

    // Done flag: set by counter ack while request high, dropped with it
    always_ff @(posedge REF_CLK_I) begin
        if (port_rst || !pu_req) begin
            done_ff <= 1'b0;
        end else if (PERF_UPDATE_ACK_I) begin
            done_ff <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Datapath reset with least hold
    // ------------------------------------------------------------
    // Stretch guards against a too-short software pulse
    logic [1:0] hold_cnt_ff;
    logic       dp_req;
    assign dp_req = port_rst | ctrl1_ff[ds3pc_pkg::BIT_DPRST];

    always_ff @(posedge REF_CLK_I) begin
        if (dp_req) begin
            hold_cnt_ff <= 2'(ds3pc_pkg::RST_HOLD_CYC);
        end else if (hold_cnt_ff != 2'h0) begin
            hold_cnt_ff <= hold_cnt_ff - 2'h1;
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        DATAPATH_RESET_O <= dp_req || (hold_cnt_ff != 2'h0);
        PORT_RESET_O     <= port_rst;
    end

    // ------------------------------------------------------------
    // Status and read port
    // ------------------------------------------------------------
    logic [15:0] stat, stat_d_ff, rd_mux;
    logic        clr_l;
    assign stat  = {12'h000, DATAPATH_RESET_O, FRAME_SYNC_LOST_I, SIGNAL_ABSENT_I, done_ff};
    assign clr_l = WR_I && (ADDR_I == ds3pc_pkg::ADDR_STATL);

    // New rising status wins over a same-cycle clear
    always_ff @(posedge REF_CLK_I) begin
        if (port_rst) begin
            stat_d_ff <= ds3pc_pkg::RST_ZERO;
            statl_ff  <= ds3pc_pkg::RST_ZERO;
        end else begin
            stat_d_ff <= stat;
            statl_ff  <= ((clr_l ? statl_ff & ~WDATA_I : statl_ff)
                         | (stat & ~stat_d_ff)) & ds3pc_pkg::MASK_STAT;
        end
    end

    always_comb begin
        unique case (ADDR_I)
            ds3pc_pkg::ADDR_CTRL1:  rd_mux = ctrl1_ff;
            ds3pc_pkg::ADDR_CTRL2:  rd_mux = ctrl2_ff;
            ds3pc_pkg::ADDR_CTRL3:  rd_mux = ctrl3_ff;
            ds3pc_pkg::ADDR_CTRL4:  rd_mux = ctrl4_ff;
            ds3pc_pkg::ADDR_INV1:   rd_mux = inv1_ff;
            ds3pc_pkg::ADDR_INV2:   rd_mux = inv2_ff;
            ds3pc_pkg::ADDR_ISR:    rd_mux = {15'h0000, |(statl_ff & statie_ff)};
            ds3pc_pkg::ADDR_STAT:   rd_mux = stat;
            ds3pc_pkg::ADDR_STATL:  rd_mux = statl_ff;
            ds3pc_pkg::ADDR_STATIE: rd_mux = statie_ff;
            default:                rd_mux = 16'h0000;
        endcase
    end

    always_ff @(posedge REF_CLK_I) begin
        if (RST_I || !RD_I) begin
            RDATA_O <= 16'h0000;
        end else begin
            RDATA_O <= rd_mux;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    sequence s_pu_rise;
        !ctrl1_ff[ds3pc_pkg::BIT_PUPD] ##1 !pu_src && ctrl1_ff[ds3pc_pkg::BIT_PUPD];
    endsequence

    a_pay_always: assert property (@(posedge REF_CLK_I) disable iff (port_rst)
        (pas == 3'h0) |=> RX_PAYLOAD_O) else $error("payload alarm not forced");
    a_pay_oof: assert property (@(posedge REF_CLK_I) disable iff (port_rst)
        (pas == 3'h5) && FRAME_SYNC_LOST_I |=> RX_PAYLOAD_O)
        else $error("frame loss alarm missing");
    a_line_override: assert property (@(posedge REF_CLK_I) disable iff (port_rst)
        tx_line_output_enable && (las == 2'h1) |=> TX_POSITIVE_RAIL_O && !TX_NEGATIVE_RAIL_O)
        else $error("line all-ones not sent");
    a_tx_line_output_enable_low: assert property (@(posedge REF_CLK_I)
        !tx_line_output_enable |=> !TX_POSITIVE_RAIL_O && !TX_LINE_CLOCK_OUT_O)
        else $error("line outputs not forced low");
    a_err_edge: assert property (@(posedge REF_CLK_I) disable iff (port_rst)
        ERR_INJECT_O |=> !ERR_INJECT_O) else $error("error inject not single pulse");
    a_perf_latch: assert property (@(posedge REF_CLK_I) disable iff (port_rst)
        s_pu_rise |=> PERF_LATCH_O) else $error("counter latch pulse missing");
    a_done_clear: assert property (@(posedge REF_CLK_I) disable iff (port_rst)
        !pu_req |=> !done_ff) else $error("done flag not cleared");
    a_dp_hold: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $fell(dp_req) |-> DATAPATH_RESET_O [*3]) else $error("datapath reset too short");
    a_soft_keep: assert property (@(posedge REF_CLK_I) disable iff (gen_rst)
        ctrl1_ff[ds3pc_pkg::BIT_SRST] && !wr_c1 |=> ctrl1_ff[ds3pc_pkg::BIT_SRST])
        else $error("soft reset bit lost");
    a_tts_off: assert property (@(posedge REF_CLK_I) disable iff (port_rst)
        !liu_on |=> !LINE_DRIVER_OE_O) else $error("driver on with interface off");
endmodule
`default_nettype wire

// ===== testbench/test_ds3pc_port_ctrl.sv
// Self-checking testbench for the port control register bank
`default_nettype none
module test_ds3pc_port_ctrl;
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    localparam logic [15:0] BASE = 16'h7C00;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [7:0]  addr  = 8'h00;
    logic [15:0] wdata = 16'h0000;
    logic        wr    = 1'b0;
    logic        rd    = 1'b0;
    logic        g_err = 1'b0;
    logic        hw_n  = 1'b1;
    logic        ack   = 1'b0;
    logic        signal_absent   = 1'b0;
    logic        frame_sync_lost   = 1'b0;
    logic [1:0]  zs    = 2'h0;
    logic [6:0]  dat   = 7'h00;
    logic [15:0] rdata;
    logic        rx_o, tx_o, pos_o, neg_o, lclk_o, oe_o, liu_o, jatx_o, jarx_o, pre_o;
    logic        bld_o, clken_o, pgen_o, err_o, plat_o, dprst_o, prst_o;
    logic [1:0]  code_o;
    int          n_errors = 0;
    int          n_tests  = 0;
    always #20 clk = ~clk;
    ds3pc_port_ctrl uut (.REF_CLK_I(clk), .RST_I(rst), .ADDR_I(addr), .WDATA_I(wdata),
        .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .HW_RESET_N_I(hw_n),
        .GLOBAL_SOFT_RESET_I(1'b0), .GLOBAL_ERR_INJECT_I(g_err), .GLOBAL_PERF_UPDATE_I(g_err),
        .PERF_UPDATE_ACK_I(ack), .SIGNAL_ABSENT_I(signal_absent), .FRAME_SYNC_LOST_I(frame_sync_lost),
        .TX_ZERO_SUPPRESS_OFF_I(zs[0]), .RX_ZERO_SUPPRESS_OFF_I(zs[1]), .RX_PAYLOAD_I(dat[0]),
        .RX_PAYLOAD_O(rx_o), .TX_SYSTEM_SERIAL_IN_I(dat[1]), .TX_PATTERN_BIT_I(dat[2]),
        .TX_PAYLOAD_O(tx_o), .TX_FRAMER_POS_I(dat[3]), .TX_FRAMER_NEG_I(dat[4]),
        .TX_DS3_AIS_I(dat[5]), .TX_LINE_CLK_I(dat[6]), .TX_POSITIVE_RAIL_O(pos_o),
        .TX_NEGATIVE_RAIL_O(neg_o), .TX_LINE_CLOCK_OUT_O(lclk_o), .LINE_DRIVER_OE_O(oe_o),
        .LIU_ENABLE_O(liu_o), .JA_IN_TX_O(jatx_o), .JA_IN_RX_O(jarx_o), .LINE_CODE_O(code_o),
        .PREAMP_EN_O(pre_o), .BUILDOUT_EN_O(bld_o), .PORT_CLK_EN_O(clken_o),
        .PATTERN_GEN_EN_O(pgen_o), .ERR_INJECT_O(err_o), .PERF_LATCH_O(plat_o),
        .DATAPATH_RESET_O(dprst_o), .PORT_RESET_O(prst_o));
    // ----------------------------------------
    // Bus, compare and expectation helpers
    // ----------------------------------------
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wreg(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rreg(input logic [7:0] a, output logic [15:0] d);
        @(posedge clk);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // Counts one-cycle pulses of the inject and latch outputs
    task automatic pulses(output int ne, output int np);
        ne = 0;
        np = 0;
        repeat (6) begin
            @(posedge clk);
            #1;
            ne += (err_o === 1'b1);
            np += (plat_o === 1'b1);
        end
    endtask
    function automatic logic alarm(input logic [2:0] c, input logic l, input logic s,
                                   input logic o);
        case (c)
            3'h0: return 1'b1;
            3'h1: return l;
            3'h3: return l;
            3'h4: return s;
            3'h5: return o;
            3'h6: return l | s | o;
            default: return 1'b0;
        endcase
    endfunction
    function automatic logic [1:0] lcode(input logic [2:0] m, input logic [1:0] z);
        if (m[2]) return ds3pc_pkg::CODE_UNI;
        return (z == 2'h3) ? ds3pc_pkg::CODE_AMI : ds3pc_pkg::CODE_ZS;
    endfunction
    task automatic complete_run;
        $display("mismatches %0d comparisons %0d", n_errors, n_tests);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        #2000000;
        n_errors++;
        complete_run();
    end
    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        logic [15:0] v;
        logic [15:0] rb;
        logic        on;
        int          ne;
        int          np;
        v = $urandom(73);
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        settle(4);
        rreg(ds3pc_pkg::ADDR_CTRL1, rb);
        chk("ctrl1 reset", 16'h0006, rb);
        chk("clock enable", 16'h0000, {15'h0, clken_o});
        chk("datapath reset", 16'h0001, {15'h0, dprst_o});
        wreg(8'h48, 16'hFFFF);
        rreg(8'h48, rb);
        chk("unused address", 16'h0000, rb);
        // Leave both resets and power-down; payload and line alarms off
        wreg(ds3pc_pkg::ADDR_CTRL1, BASE);
        settle(6);
        chk("datapath reset", 16'h0000, {15'h0, dprst_o});
        chk("clock enable", 16'h0001, {15'h0, clken_o});
        // First eight passes walk every interface mode code
        for (int i = 0; i < 16; i++) begin
            v = $urandom;
            if (i < 8) v[10:8] = i[2:0];
            zs  <= 2'($urandom);
            dat <= 7'($urandom);
            wreg(ds3pc_pkg::ADDR_CTRL2, v);
            rreg(ds3pc_pkg::ADDR_CTRL2, rb);
            chk("ctrl2", v & ds3pc_pkg::MASK_CTRL2, rb);
            settle(2);
            on = (v[10:8] inside {3'h1, 3'h2, 3'h3});
            chk("liu", {15'h0, on}, {15'h0, liu_o});
            chk("ja", {14'h0, v[10:8] == 3'h2, v[10:8] == 3'h3}, {14'h0, jatx_o, jarx_o});
            chk("line code", {14'h0, lcode(v[10:8], zs)}, {14'h0, code_o});
            chk("driver oe", {15'h0, on & ~v[14]}, {15'h0, oe_o});
            chk("preamp", {15'h0, v[13]}, {15'h0, pre_o});
            chk("buildout", {15'h0, on & v[12] & ~v[4]}, {15'h0, bld_o});
            chk("line outs", {13'h0, {3{v[15]}} & {dat[6], dat[4], dat[3]}},
                {13'h0, lclk_o, neg_o, pos_o});
        end
        wreg(ds3pc_pkg::ADDR_CTRL2, 16'h8100);
        dat <= 7'h20;
        // Line alarm codes: all-ones, auto without and with diagnostic loopback, AIS
        wreg(ds3pc_pkg::ADDR_CTRL1, BASE ^ 16'h0800);
        settle(3);
        chk("all ones", 16'h0001, {14'h0, neg_o, pos_o});
        wreg(ds3pc_pkg::ADDR_CTRL1, BASE ^ 16'h0C00);
        settle(3);
        chk("auto idle", 16'h0000, {15'h0, pos_o});
        wreg(ds3pc_pkg::ADDR_CTRL4, 16'h0400);
        settle(3);
        chk("auto loop", 16'h0001, {15'h0, pos_o});
        wreg(ds3pc_pkg::ADDR_CTRL4, 16'h0000);
        wreg(ds3pc_pkg::ADDR_CTRL1, BASE ^ 16'h0400);
        settle(3);
        chk("ais", 16'h0001, {15'h0, pos_o});
        // Every payload alarm code, second half under line loopback
        for (int i = 0; i < 16; i++) begin
            {signal_absent, frame_sync_lost} <= 2'($urandom);
            dat        <= 7'($urandom);
            wreg(ds3pc_pkg::ADDR_CTRL4, i[3] ? 16'h0200 : 16'h0000);
            wreg(ds3pc_pkg::ADDR_CTRL1, (BASE & 16'h0FFF) | {1'b0, i[2:0], 12'h000});
            settle(3);
            chk("rx payload", {15'h0, alarm(i[2:0], i[3], signal_absent, frame_sync_lost) | dat[0]},
                {15'h0, rx_o});
        end
        wreg(ds3pc_pkg::ADDR_CTRL4, 16'h0000);
        dat <= 7'h04;
        wreg(ds3pc_pkg::ADDR_CTRL1, BASE | 16'h0200);
        settle(3);
        chk("pattern on", 16'h0003, {14'h0, pgen_o, tx_o});
        wreg(ds3pc_pkg::ADDR_CTRL1, BASE);
        settle(3);
        chk("pattern off", 16'h0000, {14'h0, pgen_o, tx_o});
        // Manual error from the port bit, then error and update from global
        for (int s = 0; s < 2; s++) begin
            wreg(ds3pc_pkg::ADDR_CTRL1, BASE | (s[0] ? 16'h0050 : 16'h0000));
            if (s == 0) wreg(ds3pc_pkg::ADDR_CTRL1, BASE | 16'h0080);
            else g_err <= 1'b1;
            pulses(ne, np);
            chk("inject pulses", 16'h0001, 16'(ne));
            chk("global latch", {15'h0, s[0]}, 16'(np));
            g_err <= 1'b0;
        end
        wreg(ds3pc_pkg::ADDR_CTRL1, BASE | 16'h0008);
        pulses(ne, np);
        chk("latch pulses", 16'h0001, 16'(np));
        ack <= 1'b1;
        rreg(ds3pc_pkg::ADDR_STAT, rb);
        chk("update done", 16'h0001, rb & 16'h0001);
        wreg(ds3pc_pkg::ADDR_CTRL1, BASE);
        ack <= 1'b0;
        settle(2);
        rreg(ds3pc_pkg::ADDR_STAT, rb);
        chk("done cleared", 16'h0000, rb & 16'h0001);
        // Soft reset clears the bank but keeps its own bit
        wreg(ds3pc_pkg::ADDR_CTRL1, BASE | 16'h0001);
        settle(4);
        chk("port reset", 16'h0001, {15'h0, prst_o});
        rreg(ds3pc_pkg::ADDR_CTRL2, rb);
        chk("ctrl2 cleared", 16'h0000, rb);
        rreg(ds3pc_pkg::ADDR_CTRL1, rb);
        chk("ctrl1 in reset", 16'h0007, rb);
        wreg(ds3pc_pkg::ADDR_CTRL1, 16'h0006);
        settle(4);
        chk("port reset off", 16'h0000, {15'h0, prst_o});
        hw_n <= 1'b0;
        settle(4);
        chk("pin reset", 16'h0001, {15'h0, prst_o});
        complete_run();
    end
endmodule
`default_nettype wire
